// ---- asfifo_top.v ----
// Acceleration sample buffer with status and setup registers.
// Assumes a byte register port from the serial interface logic and a
// one-cycle sample strobe at the system output data rate.
//
// What this block does
// - Address zero shows buffer status when enabled
// - Six-bit count gives stored samples, 0..32
// - Mode 0 disables; mode 1 is circular
// - Mode 2 stops storing when full
// - Trigger mode stores 32 minus threshold more
// - Threshold sets retained pre-trigger samples
// - Flush on disable, rate change, standby exit
// - Writing mode 0 clears flags and count
// - Overflow flag bit 7 while count is 32
// - Level flag bit 6 while count >= threshold
// - Threshold zero suppresses the level flag
// - In trigger mode level flag means triggered
// - Status read clears interrupt bit; sample sets it
// - Trigger mode overflow zero before trigger
// - Trigger mode overflow means storing stopped
// - Crossing threshold never stops storing
// - Samples enter at system output data rate
// - Read returns oldest sample, pops, decrements
// - Mode writable always; threshold only standby
// - Enabled: 0x01 reads buffer, 0x02-0x06 zero
`timescale 1ns/1ps
`default_nettype none
`include "asfifo_regs.vh"
module asfifo_top #(
    parameter DEPTH = `ASFIFO_DEPTH,
    parameter SAMPLE_W = 48
) (
    input wire clk,
    input wire rst_n,
    input wire reg_rd,
    input wire reg_wr,
    input wire [7:0] reg_addr,
    input wire [7:0] reg_wdata,
    input wire [7:0] data_status,
    input wire [47:0] live_sample,
    input wire sample_strobe,
    input wire active,
    input wire sleep_wake_change,
    input wire trigger_event,
    output reg [7:0] reg_rdata,
    output reg buffer_int_bit,
    output reg overflow_flag,
    output reg level_reached_flag,
    output reg [5:0] stored_sample_count,
    output reg [7:0] fifo_setup
);
    localparam AW = 5;
    localparam [5:0] FULL = DEPTH[5:0];
    localparam [2:0] LAST_BYTE = `ASFIFO_BYTES_PER_SAMPLE - 3'h1;
    localparam [2:0] ST_RUN = 3'h1;
    localparam [2:0] ST_POST = 3'h2;
    localparam [2:0] ST_HALT = 3'h4;

    wire rst_sync_n;
    wire [SAMPLE_W-1:0] head_data;
    reg [AW-1:0] head;
    reg [AW-1:0] tail;
    reg [2:0] byte_idx;
    reg [2:0] trig_state;
    reg [5:0] post_left;
    reg active_q;
    reg [5:0] next_count;

    wire [1:0] mode = fifo_setup[`ASFIFO_MODE_HI:`ASFIFO_MODE_LO];
    wire [5:0] threshold = fifo_setup[`ASFIFO_THR_HI:`ASFIFO_THR_LO];
    wire enabled = mode != `ASFIFO_MODE_OFF;
    wire full = stored_sample_count == FULL;
    wire mode_write = reg_wr && reg_addr == `ASFIFO_ADDR_SETUP;
    wire write_off = mode_write &&
        reg_wdata[`ASFIFO_MODE_HI:`ASFIFO_MODE_LO] == `ASFIFO_MODE_OFF;
    // Flushing covers every listed cause, including the disable itself.
    wire flush = !enabled || write_off || sleep_wake_change ||
        (active && !active_q);
    wire buf_read = enabled && reg_rd && reg_addr == `ASFIFO_ADDR_READ;
    wire pop = buf_read && stored_sample_count != 6'h00 &&
        byte_idx == LAST_BYTE;
    wire halted = trig_state == ST_HALT;

    reg store;
    reg drop_oldest;
    always @* begin
        store = 1'b0;
        drop_oldest = 1'b0;
        if (enabled && sample_strobe && !flush) begin
            case (mode)
                `ASFIFO_MODE_CIRC: begin
                    store = 1'b1;
                    drop_oldest = full && !pop;
                end
                `ASFIFO_MODE_FILL: begin
                    store = !full || pop;
                end
                `ASFIFO_MODE_TRIG: begin
                    // Before the trigger the window wraps at the threshold.
                    if (trig_state == ST_RUN) begin
                        store = 1'b1;
                        drop_oldest = (stored_sample_count >= threshold ||
                            full) && !pop;
                    end else if (trig_state == ST_POST) begin
                        store = post_left != 6'h00 && (!full || pop);
                    end
                end
                default: begin
                    store = 1'b0;
                end
            endcase
        end
    end

    always @* begin
        next_count = stored_sample_count;
        if (store && !drop_oldest && !pop) begin
            next_count = stored_sample_count + 6'h01;
        end else if (!store && pop) begin
            next_count = stored_sample_count - 6'h01;
        end
    end

    asfifo_store #(
        .WIDTH(SAMPLE_W),
        .DEPTH(DEPTH),
        .AW(AW)
    ) u_store (
        .clk(clk),
        .wr_en(store),
        .wr_idx(tail),
        .wr_data(live_sample),
        .rd_idx(head),
        .rd_data(head_data)
    );

    asfifo_reset_sync u_rst (
        .clk(clk),
        .rst_n(rst_n),
        .rst_sync_n(rst_sync_n)
    );

    always @(posedge clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            fifo_setup <= `ASFIFO_SETUP_RESET;
        end else if (mode_write) begin
            fifo_setup[`ASFIFO_MODE_HI:`ASFIFO_MODE_LO] <=
                reg_wdata[`ASFIFO_MODE_HI:`ASFIFO_MODE_LO];
            if (!active) begin
                fifo_setup[`ASFIFO_THR_HI:`ASFIFO_THR_LO] <=
                    reg_wdata[`ASFIFO_THR_HI:`ASFIFO_THR_LO];
            end
        end
    end

    always @(posedge clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            head <= 5'h00;
            tail <= 5'h00;
            stored_sample_count <= 6'h00;
            byte_idx <= 3'h0;
            trig_state <= ST_RUN;
            post_left <= 6'h00;
            active_q <= 1'b0;
        end else begin
            active_q <= active;
            if (flush) begin
                head <= 5'h00;
                tail <= 5'h00;
                stored_sample_count <= 6'h00;
                byte_idx <= 3'h0;
                trig_state <= ST_RUN;
                post_left <= 6'h00;
            end else begin
                stored_sample_count <= next_count;
                if (store) begin
                    tail <= tail + 5'h01;
                end
                if (pop || drop_oldest) begin
                    head <= head + 5'h01;
                end
                if (buf_read && stored_sample_count != 6'h00) begin
                    byte_idx <= (byte_idx == LAST_BYTE) ? 3'h0 :
                        byte_idx + 3'h1;
                end
                case (trig_state)
                    ST_RUN: begin
                        if (mode == `ASFIFO_MODE_TRIG && trigger_event) begin
                            trig_state <= ST_POST;
                            post_left <= FULL - threshold;
                        end
                    end
                    ST_POST: begin
                        if (store) begin
                            post_left <= post_left - 6'h01;
                        end
                        if (post_left == 6'h00 ||
                            (post_left == 6'h01 && store)) begin
                            trig_state <= ST_HALT;
                        end
                    end
                    ST_HALT: begin
                        trig_state <= ST_HALT;
                    end
                    default: begin
                        trig_state <= ST_RUN;
                    end
                endcase
            end
        end
    end

    always @(posedge clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            overflow_flag <= 1'b0;
            level_reached_flag <= 1'b0;
        end else if (flush) begin
            overflow_flag <= 1'b0;
            level_reached_flag <= 1'b0;
        end else if (mode == `ASFIFO_MODE_TRIG) begin
            overflow_flag <= halted;
            level_reached_flag <= trig_state != ST_RUN;
        end else begin
            overflow_flag <= next_count == FULL;
            level_reached_flag <= threshold != 6'h00 &&
                next_count >= threshold;
        end
    end

    // A new sample wins over a status read in the same cycle.
    always @(posedge clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            buffer_int_bit <= 1'b0;
        end else if (flush) begin
            buffer_int_bit <= 1'b0;
        end else if (store) begin
            buffer_int_bit <= 1'b1;
        end else if (enabled && reg_rd &&
                     reg_addr == `ASFIFO_ADDR_STATUS) begin
            buffer_int_bit <= 1'b0;
        end
    end

    wire [7:0] head_byte = head_data[8*byte_idx +: 8];
    wire [7:0] status_byte = {overflow_flag, level_reached_flag,
        stored_sample_count};

    always @(posedge clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            reg_rdata <= 8'h00;
        end else if (reg_rd) begin
            if (reg_addr == `ASFIFO_ADDR_STATUS) begin
                reg_rdata <= enabled ? status_byte : data_status;
            end else if (reg_addr == `ASFIFO_ADDR_READ && enabled) begin
                reg_rdata <= (stored_sample_count != 6'h00) ?
                    head_byte : 8'h00;
            end else if (enabled && reg_addr >= `ASFIFO_ADDR_ZERO_LO &&
                         reg_addr <= `ASFIFO_ADDR_ZERO_HI) begin
                reg_rdata <= 8'h00;
            end else if (reg_addr == `ASFIFO_ADDR_SETUP) begin
                reg_rdata <= fifo_setup;
            end else begin
                reg_rdata <= 8'h00;
            end
        end
    end
endmodule
`default_nettype wire

// ---- asfifo_regs.vh ----
// Register map, field positions and counts for the acceleration sample buffer.
// Assumes inclusion by bare name from the buffer design files.
`ifndef ASFIFO_REGS_VH
`define ASFIFO_REGS_VH

`define ASFIFO_ADDR_STATUS 8'h00
`define ASFIFO_ADDR_READ 8'h01
`define ASFIFO_ADDR_ZERO_LO 8'h02
`define ASFIFO_ADDR_ZERO_HI 8'h06
`define ASFIFO_ADDR_SETUP 8'h09

`define ASFIFO_OVF_BIT 7
`define ASFIFO_LVL_BIT 6
`define ASFIFO_MODE_HI 7
`define ASFIFO_MODE_LO 6
`define ASFIFO_THR_HI 5
`define ASFIFO_THR_LO 0

`define ASFIFO_MODE_OFF 2'h0
`define ASFIFO_MODE_CIRC 2'h1
`define ASFIFO_MODE_FILL 2'h2
`define ASFIFO_MODE_TRIG 2'h3

`define ASFIFO_SETUP_RESET 8'h00
`define ASFIFO_DEPTH 32
`define ASFIFO_BYTES_PER_SAMPLE 3'h6

`endif

// ---- asfifo_store.v ----
// Flip-flop storage for buffered samples, written and read by index.
// Assumes the owner keeps the indices in range; storage holds no control.
`timescale 1ns/1ps
`default_nettype none
module asfifo_store #(
    parameter WIDTH = 48,
    parameter DEPTH = 32,
    parameter AW = 5
) (
    input wire clk,
    input wire wr_en,
    input wire [AW-1:0] wr_idx,
    input wire [WIDTH-1:0] wr_data,
    input wire [AW-1:0] rd_idx,
    output wire [WIDTH-1:0] rd_data
);
    reg [WIDTH-1:0] mem [0:DEPTH-1];
    genvar i;
    generate
        for (i = 0; i < DEPTH; i = i + 1) begin : g_entry
            always @(posedge clk) begin
                if (wr_en && wr_idx == i[AW-1:0]) begin
                    mem[i] <= wr_data;
                end
            end
        end
    endgenerate
    assign rd_data = mem[rd_idx];
endmodule
`default_nettype wire

// ---- asfifo_reset_sync.v ----
// Two-stage reset release synchroniser.
// Assumes rst_n may fall at any time; release is aligned to clk.
`timescale 1ns/1ps
`default_nettype none
module asfifo_reset_sync (
    input wire clk,
    input wire rst_n,
    output reg rst_sync_n
);
    reg stage_n;
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            stage_n <= 1'b0;
            rst_sync_n <= 1'b0;
        end else begin
            stage_n <= 1'b1;
            rst_sync_n <= stage_n;
        end
    end
endmodule
`default_nettype wire

// ---- asfifo_asserts.sv ----
// Port checks for the sample buffer.
// Assumes a bind to asfifo_top.
`timescale 1ns/1ps
`default_nettype none
module asfifo_asserts (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic reg_rd,
    input wire logic reg_wr,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] data_status,
    input wire logic sample_strobe,
    input wire logic active,
    input wire logic sleep_wake_change,
    input wire logic [7:0] reg_rdata,
    input wire logic buffer_int_bit,
    input wire logic overflow_flag,
    input wire logic level_reached_flag,
    input wire logic [5:0] stored_sample_count,
    input wire logic [7:0] fifo_setup
);
    wire [1:0] md = fifo_setup[7:6];
    wire [5:0] th = fifo_setup[5:0];
    wire [5:0] n = stored_sample_count;
    wire [7:0] st = {overflow_flag, level_reached_flag, n};
    wire quiet = !reg_rd && !reg_wr && !sleep_wake_change && active;
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    a_count_range: assert property (n <= 6'h20)
        else $error("count above depth");
    a_full_ovf: assert property ((md == 1 || md == 2) && md == $past(md)
        |-> overflow_flag == (n == 6'h20)) else $error("overflow flag wrong");
    a_level_flag: assert property ((md == 1 || md == 2) && $stable(fifo_setup)
        |-> level_reached_flag == (th != 0 && n >= th)) else $error("level flag");
    a_off_clear: assert property (md == 0 && $past(md) == 0
        |-> st == 8'h00) else $error("disabled buffer not clear");
    a_status_view: assert property (reg_rd && reg_addr == 8'h00 |=> reg_rdata ==
        ($past(md) != 0 ? $past(st) : $past(data_status))) else $error("status");
    a_zero_window: assert property (reg_rd && reg_addr >= 8'h02 && reg_addr <= 8'h06
        && md != 0 |=> reg_rdata == 8'h00) else $error("window not zero");
    a_circ_grow: assert property (md == 1 && sample_strobe && quiet
        && !$rose(active) && n < 6'h20 |=> n == $past(n) + 6'h01 && buffer_int_bit)
        else $error("circular store");
    a_fill_stop: assert property (md == 2 && n == 6'h20 && quiet
        && !$rose(active) |=> n == 6'h20) else $error("fill mode kept storing");
    a_trig_ovf: assert property (md == 3 && !level_reached_flag
        |-> !overflow_flag) else $error("overflow before trigger");
    a_trig_halt: assert property (md == 3 && overflow_flag && quiet
        && !$rose(active) |=> n == $past(n)) else $error("halted buffer stored");
    a_stat_clear: assert property (reg_rd && reg_addr == 8'h00 && md != 0
        && !sample_strobe |=> !buffer_int_bit) else $error("int bit not cleared");
endmodule
bind asfifo_top asfifo_asserts asfifo_asserts_inst (.clk(clk), .rst_n(rst_n),
    .reg_rd(reg_rd), .reg_wr(reg_wr), .reg_addr(reg_addr),
    .data_status(data_status), .sample_strobe(sample_strobe),
    .active(active), .sleep_wake_change(sleep_wake_change),
    .reg_rdata(reg_rdata), .buffer_int_bit(buffer_int_bit),
    .overflow_flag(overflow_flag), .level_reached_flag(level_reached_flag),
    .stored_sample_count(stored_sample_count), .fifo_setup(fifo_setup));
`default_nettype wire

// ---- asfifo_host.sv ----
// Host model driving the byte register port.
// Assumes read data arrives one cycle after each read pulse.
`timescale 1ns/1ps
`default_nettype none
module asfifo_host (
    input wire logic clk,
    input wire logic [7:0] reg_rdata,
    output logic reg_rd,
    output logic reg_wr,
    output logic [7:0] reg_addr,
    output logic [7:0] reg_wdata
);
    initial begin
        reg_rd = 1'b0;
        reg_wr = 1'b0;
        reg_addr = 8'h00;
        reg_wdata = 8'h00;
    end
    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        @(negedge clk);
        reg_addr = a;
        reg_wdata = v;
        reg_wr = 1'b1;
        @(negedge clk);
        reg_wr = 1'b0;
        reg_wdata = ~v;
    endtask
    // Reads run back to back, as one multibyte transfer would.
    task automatic rd(input logic [7:0] a, input int n, output logic [47:0] v);
        v = 48'h0;
        @(negedge clk);
        reg_addr = a;
        reg_rd = 1'b1;
        for (int i = 0; i < n; i++) begin
            @(negedge clk);
            if (i == n - 1) reg_rd = 1'b0;
            v[8*i +: 8] = reg_rdata;
        end
        reg_addr = ~a;
    endtask
endmodule
`default_nettype wire

// ---- tb_accel_sample_fifo.sv ----
// Self-checking bench for the sample buffer with a queue model.
// Assumes asfifo_top, asfifo_host and the checker compiled before it.
`timescale 1ns/1ps
`default_nettype none
module tb_accel_sample_fifo;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic [7:0] data_status = 8'h5a;
    logic [47:0] live_sample = 48'h0;
    logic sample_strobe = 1'b0;
    logic active = 1'b0;
    logic sleep_wake_change = 1'b0;
    logic trigger_event = 1'b0;
    logic reg_rd, reg_wr, buffer_int_bit, overflow_flag, level_reached_flag;
    logic [7:0] reg_addr, reg_wdata, reg_rdata, fifo_setup;
    logic [5:0] stored_sample_count;
    logic [47:0] d;
    logic [47:0] q[$];
    int fail_count = 0, n_checks = 0, cycles = 0;
    int md = 0, th = 0, trig = 0, post = 0;
    always #4 clk = ~clk;
    asfifo_top asfifo_top_inst (.clk(clk), .rst_n(rst_n), .reg_rd(reg_rd),
        .reg_wr(reg_wr), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .data_status(data_status), .live_sample(live_sample),
        .sample_strobe(sample_strobe), .active(active),
        .sleep_wake_change(sleep_wake_change), .trigger_event(trigger_event),
        .reg_rdata(reg_rdata), .buffer_int_bit(buffer_int_bit),
        .overflow_flag(overflow_flag), .level_reached_flag(level_reached_flag),
        .stored_sample_count(stored_sample_count), .fifo_setup(fifo_setup));
    asfifo_host asfifo_host_inst (.clk(clk), .reg_rdata(reg_rdata),
        .reg_rd(reg_rd), .reg_wr(reg_wr), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata));
    task automatic chk(input string nm, input logic [47:0] s, e);
        n_checks++;
        if (s !== e) begin
            fail_count++;
            $display("[FAIL] %s expected %h seen %h", nm, e, s);
        end
    endtask
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", n_checks, fail_count);
        if (fail_count == 0 && n_checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            fail_count++;
            wrap_up();
        end
    end
    task automatic setup(input int m, input int t);
        asfifo_host_inst.wr(8'h09, 8'h00);
        @(negedge clk);
        active = 1'b0;
        asfifo_host_inst.wr(8'h09, {m[1:0], t[5:0]});
        @(negedge clk);
        active = 1'b1;
        q.delete();
        md = m;
        th = t;
        trig = 0;
        post = 0;
    endtask
    task automatic push(input int n);
        repeat (n) begin
            @(negedge clk);
            live_sample = 48'({$urandom, $urandom});
            sample_strobe = 1'b1;
            if (md == 3 && trig != 0) begin
                if (post < 32 - th) begin
                    q.push_back(live_sample);
                    post++;
                end
            end else if (md != 2 || q.size() < 32) begin
                q.push_back(live_sample);
                if (md == 1 && q.size() > 32) void'(q.pop_front());
                if (md == 3 && q.size() > th) void'(q.pop_front());
            end
            @(negedge clk);
            sample_strobe = 1'b0;
            live_sample = ~live_sample;
        end
    endtask
    task automatic state(input string tn);
        logic [7:0] e;
        e = {md == 3 ? trig != 0 && post == 32 - th : q.size() == 32,
             md == 3 ? trig != 0 : th != 0 && q.size() >= th, 6'(q.size())};
        if (md == 0) e = 8'h00;
        asfifo_host_inst.rd(8'h00, 1, d);
        chk("status", d[7:0], md == 0 ? data_status : e);
        chk("flags", {overflow_flag, level_reached_flag}, e[7:6]);
        chk("count", stored_sample_count, e[5:0]);
        if (md != 0) chk("int bit", buffer_int_bit, 1'b0);
        $display("test %s done", tn);
    endtask
    task automatic pop();
        asfifo_host_inst.rd(8'h01, 6, d);
        chk("sample", d, q.size() ? q.pop_front() : 48'h0);
    endtask
    initial begin
        void'($urandom(32'h43adc1e7));
        repeat (6) @(negedge clk);
        rst_n = 1'b1;
        repeat (3) @(negedge clk);
        asfifo_host_inst.rd(8'h09, 1, d);
        chk("setup reset", d[7:0], 8'h00);
        state("reset");
        setup(1, 4);
        push(35);
        pop();
        pop();
        asfifo_host_inst.rd(8'h03, 1, d);
        chk("zero window", d[7:0], 8'h00);
        state("circular");
        asfifo_host_inst.wr(8'h09, 8'h49);
        chk("threshold", fifo_setup, 8'h44);
        push($urandom_range(1, 6));
        asfifo_host_inst.wr(8'h09, 8'h00);
        md = 0;
        q.delete();
        state("disable");
        setup(2, 0);
        push(34);
        state("fill full");
        pop();
        state("fill pop");
        setup(3, 5);
        push(10);
        state("pre trigger");
        @(negedge clk);
        trigger_event = 1'b1;
        @(negedge clk);
        trigger_event = 1'b0;
        trig = 1;
        push(30);
        state("post trigger");
        pop();
        state("halted pop");
        // A full-depth pre-trigger window fills and wraps with no overflow.
        setup(3, 32);
        push(34);
        state("trigger wrap");
        @(negedge clk);
        trigger_event = 1'b1;
        @(negedge clk);
        trigger_event = 1'b0;
        trig = 1;
        push(2);
        state("trigger stop");
        setup(1, 4);
        push(3);
        @(negedge clk);
        sleep_wake_change = 1'b1;
        @(negedge clk);
        sleep_wake_change = 1'b0;
        q.delete();
        state("rate flush");
        push(3);
        @(negedge clk);
        active = 1'b0;
        @(negedge clk);
        active = 1'b1;
        q.delete();
        state("standby flush");
        wrap_up();
    end
endmodule
`default_nettype wire
